/* File: logic/idc_pkg.sv */
// Types shared by the cycle-steal DMA glue.
// Assumes the register header is included by the design modules.
package idc_pkg;

  // ----------------------------------------------------------------------
  // Adapter register write port
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic [2:0] sel;
    logic [7:0] data;
  } idc_adp_wr_s;

  // ----------------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    IDC_I_SWITCH  = 5'h01,
    IDC_I_DEVADDR = 5'h02,
    IDC_I_AUX     = 5'h04,
    IDC_I_MODE    = 5'h08,
    IDC_I_DONE    = 5'h10
  } idc_init_e;

  typedef enum logic [4:0] {
    IDC_D_IDLE = 5'h01,
    IDC_D_REQ  = 5'h02,
    IDC_D_XFER = 5'h04,
    IDC_D_GAP  = 5'h08,
    IDC_D_HOLD = 5'h10
  } idc_dma_e;

endpackage

/* File: logic/idc_regs.svh */
// Register offsets, field positions and fixed values of the cycle-steal
// DMA glue. Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef IDC_REGS_SVH
`define IDC_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define IDC_OFS_CTRL       8'h00
`define IDC_OFS_STATUS     8'h04
`define IDC_OFS_COUNT      8'h08
`define IDC_OFS_ADDR       8'h0C
`define IDC_OFS_DISPLAY    8'h10

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define IDC_CTRL_ENABLE    0
`define IDC_CTRL_BURST     1
`define IDC_CTRL_RESET     2'h0

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define IDC_ST_TALKER      0
`define IDC_ST_LISTENER    1
`define IDC_ST_ACTIVE      2
`define IDC_ST_INIT_DONE   3
`define IDC_ST_EOI         4
`define IDC_ST_REMOTE      5
`define IDC_ST_BLK_LSB     8

// ----------------------------------------------------------------------
// Adapter register selects and init values
// ----------------------------------------------------------------------
`define IDC_ADP_SEL_DEVADDR 3'h4
`define IDC_ADP_SEL_AUXCMD  3'h3
`define IDC_ADP_SEL_ADRMODE 3'h2
`define IDC_AUX_RELEASE     8'h00
`define IDC_ADRMODE_VALUE   8'h80
`define IDC_SW_SETTLE       2'h3

`endif

/* File: logic/idc_top.sv */
// Cycle-steal DMA glue between a processor bus and a bus adapter.
// Assumes processor E/Q clocks, bus-available and all adapter lines are
// asynchronous pins; software reaches registers over classic Wishbone.
//
// Our own choices: the register addresses and the Wishbone register port.
`include "idc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module idc_top
  import idc_pkg::*;
#(
  parameter int           AW         = 16,
  parameter logic [15:0]  BLOCK_LEN  = 16'h0100,
  parameter logic [15:0]  START_ADDR = 16'h1000
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  // Processor clocks and bus hand-over
  input  wire logic              cpu_e,
  input  wire logic              cpu_q,
  input  wire logic              cpu_bus_avail,
  output logic                   processor_bus_request_in,
  // Block mover bus control
  output logic                   dma_grant,
  output logic                   dma_rw,
  output logic [AW-1:0]          dma_addr,
  // Bus adapter
  input  wire logic              transfer_request_out,
  input  wire logic              adp_talker,
  input  wire logic              adp_listener,
  input  wire logic              adp_remote,
  input  wire logic              bus_eoi,
  output logic                   adp_rst_b,
  output idc_adp_wr_s            adp_wr,
  // Address switches
  input  wire logic [7:0]        sw_addr,
  output logic                   sw_buf_en,
  // Display port
  output logic [7:0]             disp_digits,
  output logic [2:0]             disp_lamps
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_s1_ff;
  logic rst_n;

  // Two-stage release of the async reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_ff <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n     <= rst_s1_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_s1_ff;
  logic [NSYNC-1:0] pin_s2_ff;
  logic [7:0]       sw_s1_ff;
  logic [7:0]       sw_s2_ff;
  logic             e_d_ff;
  logic             q_d_ff;

  assign pin_raw = {bus_eoi, adp_remote, adp_listener, adp_talker,
                    transfer_request_out, cpu_bus_avail, cpu_q};

  // Two flip-flops per pin, one loop over all single-bit pins except E
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          pin_s1_ff[gi] <= 1'b0;
          pin_s2_ff[gi] <= 1'b0;
        end else begin
          pin_s1_ff[gi] <= pin_raw[gi];
          pin_s2_ff[gi] <= pin_s1_ff[gi];
        end
      end
    end
  endgenerate

  logic e_s1_ff;
  logic e_s2_ff;

  // E clock and switches, plus edge history for E and Q
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      e_s1_ff  <= 1'b0;
      e_s2_ff  <= 1'b0;
      e_d_ff   <= 1'b0;
      q_d_ff   <= 1'b0;
      sw_s1_ff <= 8'h00;
      sw_s2_ff <= 8'h00;
    end else begin
      e_s1_ff  <= cpu_e;
      e_s2_ff  <= e_s1_ff;
      e_d_ff   <= e_s2_ff;
      q_d_ff   <= pin_s2_ff[0];
      sw_s1_ff <= sw_addr;
      sw_s2_ff <= sw_s1_ff;
    end
  end

  logic q_rise;
  logic e_fall;
  logic ba_s;
  logic drq_s;
  logic talk_s;
  logic lstn_s;
  logic rem_s;
  logic eoi_s;

  assign q_rise = pin_s2_ff[0] & ~q_d_ff;
  assign e_fall = e_d_ff & ~e_s2_ff;
  assign ba_s   = pin_s2_ff[1];
  assign drq_s  = pin_s2_ff[2];  // Per byte or free slot
  assign talk_s = pin_s2_ff[3];  // Set by adapter on own address
  assign lstn_s = pin_s2_ff[4];
  assign rem_s  = pin_s2_ff[5];
  assign eoi_s  = pin_s2_ff[6];

  // ----------------------------------------------------------------------
  // Adapter initialisation sequencer
  // ----------------------------------------------------------------------
  idc_init_e   ini_ff;
  idc_init_e   nxt_ini;
  logic [1:0]  settle_ff;
  idc_adp_wr_s nxt_adp_wr;

  // Next state and adapter write for each init step
  always_comb begin
    nxt_ini    = ini_ff;
    nxt_adp_wr = '0;
    unique case (ini_ff)
      IDC_I_SWITCH: begin
        if (settle_ff == `IDC_SW_SETTLE) begin
          nxt_ini = IDC_I_DEVADDR;
        end
      end
      IDC_I_DEVADDR: begin
        // Address first; only this register is open in soft reset
        nxt_adp_wr = '{wr: 1'b1, sel: `IDC_ADP_SEL_DEVADDR,
                       data: sw_s2_ff};
        nxt_ini    = IDC_I_AUX;
      end
      IDC_I_AUX: begin
        nxt_adp_wr = '{wr: 1'b1, sel: `IDC_ADP_SEL_AUXCMD,
                       data: `IDC_AUX_RELEASE};
        nxt_ini    = IDC_I_MODE;
      end
      IDC_I_MODE: begin
        nxt_adp_wr = '{wr: 1'b1, sel: `IDC_ADP_SEL_ADRMODE,
                       data: `IDC_ADRMODE_VALUE};
        nxt_ini    = IDC_I_DONE;
      end
      IDC_I_DONE: begin
        nxt_ini = IDC_I_DONE;
      end
    endcase
  end

  // Init state, switch buffer enable and adapter write port
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ini_ff    <= IDC_I_SWITCH;
      settle_ff <= 2'h0;
      sw_buf_en <= 1'b0;
      adp_wr    <= '0;
      adp_rst_b <= 1'b0;
    end else begin
      ini_ff    <= nxt_ini;
      adp_wr    <= nxt_adp_wr;
      adp_rst_b <= 1'b1;
      sw_buf_en <= (nxt_ini == IDC_I_SWITCH);
      if (ini_ff == IDC_I_SWITCH) begin
        settle_ff <= settle_ff + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  logic [1:0] ctrl_ff;
  logic       wb_req;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // Control register write, byte lane 0 only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= `IDC_CTRL_RESET;
    end else if (wb_req && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == `IDC_OFS_CTRL) begin
      ctrl_ff <= wb_dat_i[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Channel arming and direction
  // ----------------------------------------------------------------------
  idc_dma_e   dma_ff;
  idc_dma_e   nxt_dma;
  logic       chan_en_ff;
  logic       dir_talk_ff;
  logic       armed_ff;
  logic [15:0] count_ff;
  logic [7:0]  blocks_ff;
  logic        init_done;
  logic        req_ok;
  logic        last_byte;

  assign init_done = (ini_ff == IDC_I_DONE);
  assign last_byte = (count_ff == 16'h0001);

  // Enable needs either active bit and drops at the last byte, fixed setup on arming
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chan_en_ff  <= 1'b0;
      dir_talk_ff <= 1'b0;
      armed_ff    <= 1'b0;
    end else if (!(talk_s || lstn_s) || !ctrl_ff[`IDC_CTRL_ENABLE]) begin
      chan_en_ff <= 1'b0;
      armed_ff   <= 1'b0;
    end else if (init_done && !armed_ff && dma_ff == IDC_D_IDLE) begin
      chan_en_ff  <= 1'b1;
      armed_ff    <= 1'b1;
      dir_talk_ff <= talk_s;
    end else if (dma_ff == IDC_D_XFER && e_fall && last_byte) begin
      chan_en_ff <= 1'b0;
    end
  end

  // Request gate; end-or-identify stops listener requests only
  assign req_ok = chan_en_ff & drq_s
                & ~(eoi_s & ~dir_talk_ff);

  // ----------------------------------------------------------------------
  // Cycle-steal sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_dma = dma_ff;
    unique case (dma_ff)
      IDC_D_IDLE: begin
        if (req_ok && q_rise) begin
          nxt_dma = IDC_D_REQ;
        end
      end
      IDC_D_REQ: begin
        if (ba_s) begin
          nxt_dma = IDC_D_XFER;
        end
      end
      IDC_D_XFER: begin
        if (e_fall) begin
          if (ctrl_ff[`IDC_CTRL_BURST] && !last_byte) begin
            nxt_dma = IDC_D_HOLD;
          end else begin
            nxt_dma = IDC_D_GAP;
          end
        end
      end
      IDC_D_HOLD: begin
        if (req_ok) begin
          nxt_dma = IDC_D_XFER;
        end
      end
      IDC_D_GAP: begin
        if (e_fall && !ba_s) begin
          nxt_dma = IDC_D_IDLE;
        end
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dma_ff <= IDC_D_IDLE;
    end else begin
      dma_ff <= nxt_dma;
    end
  end

  // Bus request toward processor, changes only on Q rising or release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      processor_bus_request_in <= 1'b0;
    end else if (nxt_dma == IDC_D_GAP || nxt_dma == IDC_D_IDLE) begin
      processor_bus_request_in <= 1'b0;
    end else if (dma_ff == IDC_D_IDLE && nxt_dma == IDC_D_REQ) begin
      processor_bus_request_in <= 1'b1;
    end
  end

  // Grant, direction and address; data itself is never held here
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dma_grant <= 1'b0;
      dma_rw    <= 1'b0;
      dma_addr  <= '0;
      count_ff  <= 16'h0000;
    end else begin
      dma_grant <= (nxt_dma == IDC_D_XFER);
      dma_rw    <= dir_talk_ff;
      if (!armed_ff) begin
        dma_addr <= START_ADDR[AW-1:0];
        count_ff <= BLOCK_LEN;
      end else if (dma_ff == IDC_D_XFER && e_fall) begin
        dma_addr <= dma_addr + {{(AW-1){1'b0}}, 1'b1};
        count_ff <= count_ff - 16'h0001;
      end
    end
  end

  // Completed block counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      blocks_ff <= 8'h00;
    end else if (dma_ff == IDC_D_XFER && e_fall && last_byte) begin
      blocks_ff <= blocks_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Display port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      disp_digits <= 8'h00;
      disp_lamps  <= 3'h0;
    end else if (init_done) begin
      disp_digits <= blocks_ff;
      disp_lamps  <= {rem_s, lstn_s, talk_s};
    end
  end

  // ----------------------------------------------------------------------
  // Wishbone read and acknowledge
  // ----------------------------------------------------------------------
  logic [31:0] rd_data;

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      `IDC_OFS_CTRL:    rd_data[1:0] = ctrl_ff;
      `IDC_OFS_STATUS: begin
        rd_data[`IDC_ST_TALKER]    = talk_s;
        rd_data[`IDC_ST_LISTENER]  = lstn_s;
        rd_data[`IDC_ST_ACTIVE]    = chan_en_ff;
        rd_data[`IDC_ST_INIT_DONE] = init_done;
        rd_data[`IDC_ST_EOI]       = eoi_s;
        rd_data[`IDC_ST_REMOTE]    = rem_s;
        rd_data[`IDC_ST_BLK_LSB +: 8] = blocks_ff;
      end
      `IDC_OFS_COUNT:   rd_data[15:0] = count_ff;
      `IDC_OFS_ADDR:    rd_data[AW-1:0] = dma_addr;
      `IDC_OFS_DISPLAY: rd_data[10:0] = {disp_lamps, disp_digits};
      default:          rd_data = 32'h0000_0000;
    endcase
  end

  // One-cycle acknowledge for every access
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

/* File: testbench/idc_far_model.sv */
// Far side of the glue: processor clocks, bus hand-over and adapter.
// Assumes clk_sys is the only clock; E and Q run at clk_sys / 16.
`timescale 1ns/1ps
`default_nettype none

module idc_far_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // Stimulus from the bench
  input  wire logic       armed,
  input  wire logic [2:0] gap_e,
  // Glue side
  input  wire logic       processor_bus_request_in,
  input  wire logic       dma_grant,
  output logic            cpu_e,
  output logic            cpu_q,
  output logic            cpu_bus_avail,
  output logic            transfer_request_out
);
  logic [3:0] ph_ff;
  logic [1:0] av_ff;
  logic [2:0] wait_ff;
  logic       req_ff;
  logic       g_prev_ff;

  // E high in phases 8..15, Q leads E by a quarter
  always_ff @(posedge clk_sys) begin
    ph_ff <= (rst_b === 1'h0) ? 4'h0 : ph_ff + 4'h1;
  end
  assign cpu_e = ph_ff[3];
  assign cpu_q = ph_ff[3] ^ ph_ff[2];

  // Processor floats its bus two clocks after a request
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      av_ff <= 2'h0;
    end else begin
      av_ff <= {av_ff[0], processor_bus_request_in};
    end
  end
  assign cpu_bus_avail = av_ff[1];

  // Adapter: one request per byte, then a pause of gap_e E cycles
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      req_ff    <= 1'h0;
      wait_ff   <= 3'h0;
      g_prev_ff <= 1'h0;
    end else begin
      g_prev_ff <= dma_grant;
      if (dma_grant && !g_prev_ff) begin
        req_ff  <= 1'h0;
        wait_ff <= gap_e;
      end else if (wait_ff != 3'h0) begin
        if (ph_ff == 4'hF) begin
          wait_ff <= wait_ff - 3'h1;
        end
      end else begin
        req_ff <= armed;
      end
    end
  end
  assign transfer_request_out = req_ff;
endmodule

`default_nettype wire

/* File: testbench/idc_top_chk.sv */
// Port-level checker for the cycle-steal glue, bound into idc_top.
// Assumes control writes go to offset 0 with the burst bit in bit 1.
`timescale 1ns/1ps
`default_nettype none

module idc_top_chk
  import idc_pkg::*;
#(
  parameter int AW = 16
) (
  input wire logic          clk_sys,
  input wire logic          rst_b,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_ack_o,
  input wire logic          wb_we_i,
  input wire logic [7:0]    wb_adr_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic          cpu_e,
  input wire logic          cpu_q,
  input wire logic          cpu_bus_avail,
  input wire logic          processor_bus_request_in,
  input wire logic          dma_grant,
  input wire logic          dma_rw,
  input wire logic [AW-1:0] dma_addr,
  input wire logic          adp_talker,
  input wire logic          adp_listener,
  input wire logic          bus_eoi,
  input wire idc_adp_wr_s   adp_wr,
  input wire logic [7:0]    sw_addr,
  input wire logic          sw_buf_en
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // E falls seen since the request last dropped, saturating
  logic       e_prev_ff;
  logic [1:0] efall_ff;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      e_prev_ff <= 1'h0;
      efall_ff  <= 2'h3;
    end else begin
      e_prev_ff <= cpu_e;
      if ($fell(processor_bus_request_in)) begin
        efall_ff <= 2'h0;
      end else if (e_prev_ff && !cpu_e && efall_ff != 2'h3) begin
        efall_ff <= efall_ff + 2'h1;
      end
    end
  end

  // Burst bit as last written to the control register
  logic burst_ff;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      burst_ff <= 1'h0;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
                 && wb_adr_i == 8'h00) begin
      burst_ff <= wb_dat_i[1];
    end
  end

  sequence s_dev;
    adp_wr.wr && adp_wr.sel == 3'h4 && adp_wr.data == sw_addr;
  endsequence
  sequence s_aux;
    adp_wr.wr && adp_wr.sel == 3'h3 && adp_wr.data == 8'h00;
  endsequence
  sequence s_mode;
    adp_wr.wr && adp_wr.sel == 3'h2 && adp_wr.data == 8'h80;
  endsequence

  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_req_q;
    $rose(processor_bus_request_in) |-> cpu_q;
  endproperty
  property p_gnt_avail;
    $rose(dma_grant) |-> processor_bus_request_in && $past(cpu_bus_avail, 2);
  endproperty
  property p_steal;
    $fell(dma_grant) |-> (burst_ff || !processor_bus_request_in)
      && dma_addr == $past(dma_addr) + 1'h1;
  endproperty
  property p_rel_end;
    $fell(processor_bus_request_in) |-> $fell(dma_grant);
  endproperty
  property p_gap;
    $rose(processor_bus_request_in) |-> efall_ff != 2'h0;
  endproperty
  property p_eoi;
    (bus_eoi && !dma_rw && !processor_bus_request_in)[*4]
      |=> !processor_bus_request_in;
  endproperty
  property p_init;
    $fell(sw_buf_en) |-> ##[0:1] s_dev ##1 s_aux ##1 s_mode;
  endproperty
  property p_dir;
    $rose(processor_bus_request_in) && (adp_talker ^ adp_listener)
      |-> dma_rw == adp_talker;
  endproperty

  a_ack_resp: assert property (p_ack_resp) else $error("no ack");
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  a_req_q: assert property (p_req_q) else $error("request off Q");
  a_gnt_avail: assert property (p_gnt_avail) else $error("early grant");
  a_steal: assert property (p_steal) else $error("steal end bad");
  a_gap: assert property (p_gap) else $error("no E gap");
  a_rel_end: assert property (p_rel_end) else $error("bus back early");
  a_eoi: assert property (p_eoi) else $error("eoi ignored");
  a_init: assert property (p_init) else $error("init order");
  a_dir: assert property (p_dir) else $error("bad direction");
endmodule

bind idc_top idc_top_chk #(.AW(AW)) u_idc_top_chk (.*);

`default_nettype wire

/* File: testbench/test_ieee488_dma_cycle_steal_control.sv */
// Bench for idc_top: register tasks over classic Wishbone, talker and
// listener blocks. Assumes idc_far_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none

module test_ieee488_dma_cycle_steal_control
  import idc_pkg::*;
;
  logic        clk_sys, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i, sw_addr, disp_digits;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        cpu_e, cpu_q, cpu_bus_avail, processor_bus_request_in;
  logic        dma_grant, dma_rw, transfer_request_out, adp_talker;
  logic        adp_listener, adp_remote, bus_eoi, adp_rst_b, sw_buf_en;
  logic        g_prev, r_prev;
  logic [15:0] dma_addr;
  logic [2:0]  disp_lamps, gap_e;
  idc_adp_wr_s adp_wr;
  int          bad_count, check_count, grant_cnt, rel_cnt;

  idc_top #(.BLOCK_LEN(16'h0004)) u_idc_top (.*);

  idc_far_model u_idc_far_model (
    .clk_sys                  (clk_sys),
    .rst_b                    (rst_b),
    .armed                    (adp_talker | adp_listener),
    .gap_e                    (gap_e),
    .processor_bus_request_in (processor_bus_request_in),
    .dma_grant                (dma_grant),
    .cpu_e                    (cpu_e),
    .cpu_q                    (cpu_q),
    .cpu_bus_avail            (cpu_bus_avail),
    .transfer_request_out     (transfer_request_out)
  );

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Stolen bytes and bus request releases seen
  always @(posedge clk_sys) begin
    if (dma_grant === 1'h1 && g_prev === 1'h0) grant_cnt++;
    if (processor_bus_request_in === 1'h0 && r_prev === 1'h1) rel_cnt++;
    g_prev <= dma_grant;
    r_prev <= processor_bus_request_in;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] a,
                         input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    check({31'h0, wb_ack_o}, 32'h1, "bus answer");
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i  <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask,
                        input logic [31:0] exp, input string what);
    wb_xfer(1'h0, a, 32'h0);
    check(rd & mask, exp, what);
  endtask

  task automatic wait_gnt(input int n);
    int k;
    k = 0;
    while (grant_cnt < n && k < 5000) begin
      @(posedge clk_sys);
      k++;
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    print_verdict;
  end

  // Main sequence
  initial begin
    rst_b = 1'h0;
    {wb_cyc_i, wb_stb_i, wb_we_i, adp_talker, adp_listener} = 5'h0;
    {adp_remote, bus_eoi, g_prev, r_prev} = 4'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    sw_addr = 8'h1B;
    gap_e = 3'h1;
    grant_cnt = 0;
    rel_cnt = 0;
    bad_count = 0;
    check_count = 0;
    repeat (10) @(posedge clk_sys);
    check({adp_rst_b, disp_digits, disp_lamps}, 32'h0, "reset");
    rst_b <= 1'h1;
    repeat (20) @(posedge clk_sys);
    check({disp_digits, disp_lamps}, 32'h0, "display");
    rd_chk(8'h04, 32'h0C, 32'h08, "idle status");
    wb_xfer(1'h1, 8'h20, 32'hFF);
    rd_chk(8'h20, 32'hFFFFFFFF, 32'h0, "unmapped");
    wb_xfer(1'h1, 8'h00, 32'h1);
    rd_chk(8'h00, 32'h3, 32'h1, "ctrl");
    $display("test init done");
    // Talker block with end-or-identify raised mid-block
    adp_talker <= 1'h1;
    wait_gnt(1);
    bus_eoi <= 1'h1;
    wait_gnt(4);
    repeat (300) @(posedge clk_sys);
    check(32'(grant_cnt), 32'h4, "talker bytes");
    check({31'h0, dma_rw}, 32'h1, "talker rw");
    rd_chk(8'h0C, 32'hFFFF, 32'h1004, "talker end");
    rd_chk(8'h04, 32'hFF3F, 32'h0119, "talker status");
    check({disp_digits, disp_lamps}, {8'h01, 3'h1}, "disp");
    $display("test talker done");
    // Unaddressed, then listener stopped by end-or-identify
    adp_talker <= 1'h0;
    bus_eoi <= 1'h0;
    repeat (40) @(posedge clk_sys);
    rd_chk(8'h04, 32'h4, 32'h0, "disarmed");
    adp_listener <= 1'h1;
    adp_remote <= 1'h1;
    gap_e <= 3'h7;
    wait_gnt(6);
    bus_eoi <= 1'h1;
    repeat (2000) @(posedge clk_sys);
    check(32'(grant_cnt), 32'h6, "listener bytes");
    check({31'h0, dma_rw}, 32'h0, "listener rw");
    rd_chk(8'h0C, 32'hFFFF, 32'h1002, "listener addr");
    rd_chk(8'h08, 32'hFFFF, 32'h2, "listener count");
    rd_chk(8'h04, 32'hFF3F, 32'h013E, "listener status");
    check({disp_digits, disp_lamps}, {8'h01, 3'h6}, "disp");
    $display("test listener done");
    // Unlisten clears the stopped channel, then a burst talker block
    adp_listener <= 1'h0;
    bus_eoi <= 1'h0;
    repeat (40) @(posedge clk_sys);
    rd_chk(8'h04, 32'h4, 32'h0, "unlistened");
    wb_xfer(1'h1, 8'h00, 32'h3);
    adp_talker <= 1'h1;
    gap_e <= 3'h1;
    wait_gnt(10);
    repeat (300) @(posedge clk_sys);
    check(32'(grant_cnt), 32'hA, "burst bytes");
    check(32'(rel_cnt), 32'h7, "burst releases");
    rd_chk(8'h0C, 32'hFFFF, 32'h1004, "burst end");
    $display("test burst done");
    print_verdict;
  end
endmodule

`default_nettype wire
